// File: apsr_defs.svh
// Purpose: Timing and width constants for the pseudo-static RAM controller.
// Assumes: 125 MHz system clock, 8 ns period; slower (70 ns) grade timing.
// Notes: Cycle counts derive from the figures in ns by ceiling division.
`ifndef APSR_DEFS_SVH
`define APSR_DEFS_SVH

`define APSR_CLK_PERIOD_NS 8
`define APSR_ADDR_W 20
`define APSR_DATA_W 16
// Least read cycle time in ns, and in whole cycles rounded up.
`define APSR_T_RC_NS 70
`define APSR_RC_CYC ((`APSR_T_RC_NS + `APSR_CLK_PERIOD_NS - 1) / `APSR_CLK_PERIOD_NS)
// Least write pulse and address-to-write-end time in ns, and in cycles.
`define APSR_T_PWE_NS 60
`define APSR_PWE_CYC ((`APSR_T_PWE_NS + `APSR_CLK_PERIOD_NS - 1) / `APSR_CLK_PERIOD_NS)
// Least data setup before write end, in ns.
`define APSR_T_SD_NS 30
// Longest write strobe pulse in ns; the write pulse stays far below it.
`define APSR_T_PWE_MAX_NS 15000
// Counter width for the access timers.
`define APSR_CNT_W 5

`endif

// File: apsr_pkg.sv
// Purpose: Types shared by the pseudo-static RAM controller.
// Assumes: Widths from apsr_defs.svh.
// Notes: Requests and pin groups travel as packed structs.
`include "apsr_defs.svh"
package apsr_pkg;

	// A request from the user side.
	typedef struct packed {
		logic write;
		logic [1:0] lane_en;
		logic [`APSR_ADDR_W-1:0] addr;
		logic [`APSR_DATA_W-1:0] wdata;
	} apsr_req_t;

	// The control pins toward the memory, all but the secondary select active low.
	typedef struct packed {
		logic primary_select_n;
		logic secondary_select;
		logic out_gate_n;
		logic write_strobe_n;
		logic low_lane_enable_n;
		logic high_lane_enable_n;
	} apsr_ctl_t;

endpackage

// File: apsr_ctrl.sv
// Purpose: Host controller driving an asynchronous 1M x 16 pseudo-static RAM.
// Assumes: Memory pins are timed from this clock; read data meets setup at the sample edge.
// Notes: One access at a time; each access keeps its address for a full read cycle time.
// Behaviour
// - Write strobe stays high during every read.
// - Address valid before primary select falls.
// - Address stable 60 ns before write end.
// - No fast address changes in long cycles.
// - Low strobe writes, high strobe reads.
`timescale 1ns/100ps
`default_nettype none
`include "apsr_defs.svh"
module apsr_ctrl (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// User request port.
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire apsr_pkg::apsr_req_t i_req,
	// User read answer.
	output logic o_rd_valid,
	output logic [`APSR_DATA_W-1:0] o_rd_data,
	// Memory pins.
	output apsr_pkg::apsr_ctl_t o_mem_ctl,
	output logic [`APSR_ADDR_W-1:0] o_mem_addr,
	input wire logic [`APSR_DATA_W-1:0] i_mem_dq,
	output logic [`APSR_DATA_W-1:0] o_mem_dq,
	output logic o_mem_dq_oe
);

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_END} apsr_state_t;

	localparam logic [`APSR_CNT_W-1:0] RC_CNT = `APSR_CNT_W'(`APSR_RC_CYC);
	localparam logic [`APSR_CNT_W-1:0] PWE_CNT = `APSR_CNT_W'(`APSR_PWE_CYC);

	apsr_state_t state_reg;
	logic [`APSR_CNT_W-1:0] cnt_reg;
	apsr_pkg::apsr_req_t req_reg;
	apsr_pkg::apsr_ctl_t ctl_reg;
	logic [`APSR_DATA_W-1:0] rd_data_reg;
	logic rd_valid_reg;
	logic dq_oe_reg;

	// A request is taken only in idle, so one access runs at a time.
	assign o_req_ready = (state_reg == ST_IDLE);
	assign o_mem_ctl = ctl_reg;
	assign o_mem_addr = req_reg.addr;
	assign o_mem_dq = req_reg.wdata;
	assign o_mem_dq_oe = dq_oe_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_rd_data = rd_data_reg;

	// Sequencer: idle, address setup, timed access, release.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (i_req_valid && (i_req.lane_en != 2'h0)) begin
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					state_reg <= ST_ACCESS;
					cnt_reg <= req_reg.write ? PWE_CNT : RC_CNT;
				end
				ST_ACCESS: begin
					cnt_reg <= cnt_reg - `APSR_CNT_W'(1);
					if (cnt_reg == `APSR_CNT_W'(1)) begin
						state_reg <= ST_END;
					end
				end
				ST_END: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Request capture; the address holds from setup through release.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			req_reg <= '0;
		end else if (state_reg == ST_IDLE && i_req_valid && (i_req.lane_en != 2'h0)) begin
			req_reg <= i_req;
		end
	end

	// Control pins: selects and lanes open in access, the strobe sets the direction.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ctl_reg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		end else if (state_reg == ST_SETUP) begin
			ctl_reg.primary_select_n <= 1'b0;
			ctl_reg.secondary_select <= 1'b1;
			ctl_reg.out_gate_n <= req_reg.write;
			ctl_reg.write_strobe_n <= ~req_reg.write;
			ctl_reg.low_lane_enable_n <= ~req_reg.lane_en[0];
			ctl_reg.high_lane_enable_n <= ~req_reg.lane_en[1];
		end else if (state_reg == ST_ACCESS && cnt_reg == `APSR_CNT_W'(1)) begin
			// The strobe rises first and ends the write with data still driven.
			ctl_reg.write_strobe_n <= 1'b1;
			ctl_reg.out_gate_n <= 1'b1;
		end else if (state_reg == ST_END) begin
			ctl_reg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		end
	end

	// Data drive spans the strobe pulse and one cycle beyond its end for hold.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			dq_oe_reg <= 1'b0;
		end else if (state_reg == ST_SETUP) begin
			dq_oe_reg <= req_reg.write;
		end else if (state_reg == ST_END) begin
			dq_oe_reg <= 1'b0;
		end
	end

	// Read data sampled at the last access cycle; disabled lanes read zero.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= 1'b0;
			if (state_reg == ST_ACCESS && cnt_reg == `APSR_CNT_W'(1) && !req_reg.write) begin
				rd_data_reg <= i_mem_dq & {{8{req_reg.lane_en[1]}}, {8{req_reg.lane_en[0]}}};
				rd_valid_reg <= 1'b1;
			end
		end
	end

	// Named steps of a write as seen on the pins.
	sequence s_wr_start;
		!o_mem_ctl.write_strobe_n && $fell(o_mem_ctl.write_strobe_n);
	endsequence

	property p_write_len;
		@(posedge i_sys_clk) disable iff (i_reset)
		s_wr_start |-> !o_mem_ctl.write_strobe_n [*8] ##1 o_mem_ctl.write_strobe_n;
	endproperty
	a_write_len: assert property (p_write_len) else $error("Write pulse not eight cycles.");

	property p_read_strobe;
		@(posedge i_sys_clk) disable iff (i_reset)
		!o_mem_ctl.out_gate_n |-> o_mem_ctl.write_strobe_n;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("Strobe low during read.");

	property p_write_all_active;
		@(posedge i_sys_clk) disable iff (i_reset)
		!o_mem_ctl.write_strobe_n |-> !o_mem_ctl.primary_select_n && o_mem_ctl.secondary_select
			&& !(o_mem_ctl.low_lane_enable_n && o_mem_ctl.high_lane_enable_n) && o_mem_dq_oe;
	endproperty
	a_write_all_active: assert property (p_write_all_active) else $error("Write without full select.");

	property p_data_hold;
		@(posedge i_sys_clk) disable iff (i_reset)
		$rose(o_mem_ctl.write_strobe_n) |-> o_mem_dq_oe && $stable(o_mem_dq) && $stable(o_mem_addr);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("Data moved at write end.");

	property p_addr_first;
		@(posedge i_sys_clk) disable iff (i_reset)
		$fell(o_mem_ctl.primary_select_n) |-> $stable(o_mem_addr);
	endproperty
	a_addr_first: assert property (p_addr_first) else $error("Address changed at select.");

	property p_read_len;
		@(posedge i_sys_clk) disable iff (i_reset)
		$fell(o_mem_ctl.out_gate_n) |-> ##9 o_rd_valid;
	endproperty
	a_read_len: assert property (p_read_len) else $error("Read answer not after nine cycles.");

	property p_no_contention;
		@(posedge i_sys_clk) disable iff (i_reset)
		!o_mem_ctl.out_gate_n |-> !o_mem_dq_oe;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("Bus driven while memory drives.");

	property p_standby;
		@(posedge i_sys_clk) disable iff (i_reset)
		o_req_ready |-> o_mem_ctl.primary_select_n && !o_mem_dq_oe;
	endproperty
	a_standby: assert property (p_standby) else $error("Idle but selected.");

	// Opening of an access as seen on the pins.
	sequence s_sel_open;
		$fell(o_mem_ctl.primary_select_n);
	endsequence

	// The strobe level and the data drive must agree on the direction.
	property p_direction;
		@(posedge i_sys_clk) disable iff (i_reset)
		s_sel_open |-> (o_mem_ctl.write_strobe_n != o_mem_dq_oe);
	endproperty
	a_direction: assert property (p_direction) else $error("Strobe and data drive disagree.");

	// The address may not move while the memory stays selected.
	property p_addr_steady;
		@(posedge i_sys_clk) disable iff (i_reset)
		!o_mem_ctl.primary_select_n && $past(!o_mem_ctl.primary_select_n) |-> $stable(o_mem_addr);
	endproperty
	a_addr_steady: assert property (p_addr_steady) else $error("Address moved during access.");

	// A lane that was not asked for reads back as zero.
	property p_lane_zero;
		@(posedge i_sys_clk) disable iff (i_reset)
		o_rd_valid |-> (req_reg.lane_en[0] || o_rd_data[7:0] == 8'h00)
			&& (req_reg.lane_en[1] || o_rd_data[15:8] == 8'h00);
	endproperty
	a_lane_zero: assert property (p_lane_zero) else $error("Disabled lane read nonzero.");

	// Closing an access releases every select, both lanes and the data drive together.
	property p_release;
		@(posedge i_sys_clk) disable iff (i_reset)
		$rose(o_mem_ctl.primary_select_n) |-> !o_mem_ctl.secondary_select && o_mem_ctl.low_lane_enable_n
			&& o_mem_ctl.high_lane_enable_n && !o_mem_dq_oe;
	endproperty
	a_release: assert property (p_release) else $error("Access not fully released.");

endmodule
`default_nettype wire

// File: apsr_mem_model.sv
// Purpose: Pin model of the pseudo-static RAM.
// Assumes: Only the low ten address bits are stored.
// Notes: A released lane shows the inverse of its last value.
`timescale 1ns/100ps
`default_nettype none
module apsr_mem_model (
	// Memory pins.
	input wire apsr_pkg::apsr_ctl_t i_ctl,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq
);
	logic [15:0] mem [1024];
	logic sel;
	logic wr;
	// Selection and the write overlap.
	assign sel = !i_ctl.primary_select_n && i_ctl.secondary_select;
	assign wr = sel && !i_ctl.write_strobe_n && !(i_ctl.low_lane_enable_n && i_ctl.high_lane_enable_n);
	// Enabled bytes follow the bus while the write lasts, so the value before the ending edge stays.
	always @(*) begin
		if (wr && !i_ctl.low_lane_enable_n) mem[i_addr[9:0]][7:0] = i_dq[7:0];
		if (wr && !i_ctl.high_lane_enable_n) mem[i_addr[9:0]][15:8] = i_dq[15:8];
	end
	// A lane is driven only on a gated read; new address gives new data.
	initial o_dq = 16'ha5a5;
	always @(i_ctl, i_addr) begin
		if (sel && i_ctl.write_strobe_n && !i_ctl.out_gate_n && !i_ctl.low_lane_enable_n) o_dq[7:0] = mem[i_addr[9:0]][7:0];
		else o_dq[7:0] = ~o_dq[7:0];
		if (sel && i_ctl.write_strobe_n && !i_ctl.out_gate_n && !i_ctl.high_lane_enable_n) o_dq[15:8] = mem[i_addr[9:0]][15:8];
		else o_dq[15:8] = ~o_dq[15:8];
	end
endmodule
`default_nettype wire

// File: apsr_ctrl_tb.sv
// Purpose: Self-checking bench of the RAM controller.
// Assumes: The memory model answers on the shared data wire.
// Notes: Each scenario is one task.
`timescale 1ns/100ps
`default_nettype none
`include "apsr_defs.svh"
module apsr_ctrl_tb;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_req_valid = 1'b0;
	apsr_pkg::apsr_req_t i_req = '0;
	logic o_req_ready, o_rd_valid, o_mem_dq_oe;
	logic [15:0] o_rd_data, o_mem_dq, model_dq, dq_wire;
	logic [19:0] o_mem_addr;
	apsr_pkg::apsr_ctl_t o_mem_ctl;
	int error_cnt = 0;
	int samples_checked = 0;
	// What the pin watcher saw during the last access.
	logic [15:0] rd_last;
	logic [19:0] sel_addr;
	int lo_cyc;
	int gate_cyc;
	int strobe_bad;
	// Clock of 8 ns.
	always #4 i_sys_clk = ~i_sys_clk;
	// Level of the shared data wire.
	assign dq_wire = o_mem_dq_oe ? o_mem_dq : model_dq;
	apsr_ctrl DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
		.o_req_ready(o_req_ready), .i_req(i_req), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
		.o_mem_ctl(o_mem_ctl), .o_mem_addr(o_mem_addr), .i_mem_dq(dq_wire), .o_mem_dq(o_mem_dq),
		.o_mem_dq_oe(o_mem_dq_oe));
	apsr_mem_model ram (.i_ctl(o_mem_ctl), .i_addr(o_mem_addr), .i_dq(dq_wire), .o_dq(model_dq));
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// The request stands until the edge that takes it; the pins are then watched until ready returns.
	task automatic access(input logic w, input logic [1:0] ln, input logic [19:0] a, input logic [15:0] d);
		int n;
		logic opened;
		opened = 1'b0;
		rd_last = 16'hxxxx;
		sel_addr = 20'hxxxxx;
		lo_cyc = 0;
		gate_cyc = 0;
		strobe_bad = 0;
		@(posedge i_sys_clk);
		i_req_valid <= 1'b1;
		i_req <= '{w, ln, a, d};
		@(negedge i_sys_clk);
		for (n = 0; n < 40 && o_req_ready !== 1'b1; n++) @(negedge i_sys_clk);
		@(posedge i_sys_clk);
		i_req_valid <= 1'b0;
		if (n == 40) begin
			error_cnt++;
			conclude();
		end
		@(negedge i_sys_clk);
		for (n = 0; n < 30 && o_req_ready !== 1'b1; n++) begin
			if (o_mem_ctl.primary_select_n === 1'b0 && !opened) begin
				opened = 1'b1;
				sel_addr = o_mem_addr;
			end
			if (o_mem_ctl.write_strobe_n === 1'b0) lo_cyc++;
			if (o_mem_ctl.out_gate_n === 1'b0) gate_cyc++;
			if (o_mem_ctl.out_gate_n === 1'b0 && o_mem_ctl.write_strobe_n !== 1'b1) strobe_bad++;
			if (o_rd_valid === 1'b1) rd_last = o_rd_data;
			@(negedge i_sys_clk);
		end
		if (n == 30) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic rd(input logic [1:0] ln, input logic [19:0] a, input logic [15:0] exp);
		access(1'b0, ln, a, 16'h0000);
		check({4'h0, rd_last}, {4'h0, exp});
		check(sel_addr, a);
		check(20'(gate_cyc), 20'(`APSR_RC_CYC));
		check(20'(strobe_bad), 20'h00000);
	endtask
	task automatic wr(input logic [1:0] ln, input logic [19:0] a, input logic [15:0] d);
		access(1'b1, ln, a, d);
		check(sel_addr, a);
		check(20'(lo_cyc), 20'(`APSR_PWE_CYC));
	endtask
	// Byte lanes write and read on their own.
	task automatic s_lanes;
		wr(2'b11, 20'h00005, 16'h1234);
		wr(2'b01, 20'h00005, 16'hffab);
		wr(2'b10, 20'h00005, 16'hcdff);
		rd(2'b11, 20'h00005, 16'hcdab);
		rd(2'b01, 20'h00005, 16'h00ab);
		rd(2'b10, 20'h00005, 16'hcd00);
	endtask
	// A request with no lanes writes nothing.
	task automatic s_none;
		access(1'b1, 2'b00, 20'h00005, 16'h0000);
		check(20'(lo_cyc), 20'h00000);
		rd(2'b11, 20'h00005, 16'hcdab);
	endtask
	// Back-to-back writes and reads at the top address and at 003fe.
	task automatic s_b2b;
		wr(2'b11, 20'hfffff, 16'h5aa5);
		wr(2'b11, 20'h003fe, 16'h0ff0);
		rd(2'b11, 20'hfffff, 16'h5aa5);
		rd(2'b11, 20'h003fe, 16'h0ff0);
	endtask
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		s_lanes();
		s_none();
		s_b2b();
		conclude();
	end
endmodule
`default_nettype wire
